// >>> hdl/dpr_pkg.sv
/*
 * dpr_pkg: register map, field positions, reset values, modes and
 * carrier types of the drive position range and positioning block.
 * Assumes a 32-bit APB slave with word-aligned byte offsets.
 */
package dpr_pkg;

    // position values are four-byte signed in position scaling units
    typedef logic signed [31:0] dpr_pos_t;

    typedef struct packed {
        dpr_pos_t underflow;
        dpr_pos_t overflow;
    } dpr_limits_t;

    typedef enum logic [1:0] {
        DPR_ST_IDLE  = 2'b01,
        DPR_ST_APPLY = 2'b10
    } dpr_state_t;

    localparam int ADDR_W = 8;

    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_STATUS   = 8'h04;
    localparam logic [7:0] OFF_POS_CMD  = 8'h08;
    localparam logic [7:0] OFF_POS_ACT  = 8'h0C;
    localparam logic [7:0] OFF_UNDER    = 8'h10;
    localparam logic [7:0] OFF_OVER     = 8'h14;
    localparam logic [7:0] OFF_MODULO   = 8'h18;
    localparam logic [7:0] OFF_POLARITY = 8'h1C;
    localparam logic [7:0] OFF_SCALING  = 8'h20;
    localparam logic [7:0] OFF_PCMD     = 8'h24;
    localparam logic [7:0] OFF_PCW      = 8'h28;
    localparam logic [7:0] OFF_TARGET   = 8'h2C;
    localparam logic [7:0] OFF_COFFSET  = 8'h30;
    localparam logic [7:0] OFF_COORD    = 8'h34;
    localparam logic [7:0] OFF_PASSWORD = 8'h38;
    localparam logic [7:0] OFF_PROT0    = 8'h40;
    localparam logic [7:0] OFF_MODE0    = 8'h60;

    localparam int PROT_N = 4;
    localparam int MODE_N = 8;

    localparam int CW_SEL_HI   = 11;
    localparam int CW_SEL_MID  = 9;
    localparam int CW_SEL_LO   = 8;
    localparam int SW_ACT_HI   = 10;
    localparam int SW_ACT_MID  = 9;
    localparam int SW_ACT_LO   = 8;
    localparam int SW_LIM_EN   = 0;
    localparam int PCW_TOGGLE  = 0;
    localparam int PCW_ABS     = 1;
    localparam int POL_LIM_EN  = 7;
    localparam int SCL_ABS     = 6;

    localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
    localparam logic [15:0] RST_MODE     = 16'h0000;
    localparam logic [7:0]  RST_PROT     = 8'hFF;
    // arbitrary unlock value
    localparam logic [31:0] PASSWORD_KEY = 32'h0000_5A5A;
    // arbitrary mode definition code meaning positioning
    localparam logic [15:0] MODE_POSITIONING = 16'h000B;

endpackage

// >>> hdl/dpr_core.sv
/*
 * dpr_core: drive position range handling (limit wrap of actual and
 * commanded position), positioning command with toggle start, coordinate
 * offset bookkeeping, password write protection, operation mode select.
 * Assumes an APB master on pclk; cyclic telegram words arrive as writes.
 */
// Design decisions made here: the APB interface to the registers and the register offsets.
// Behaviour
// RULE1: modulo range programmed before range use
// RULE2: limits needed for endless axis modes
// RULE3: reaching limits wraps actual and commanded position
// RULE4: limits enabled by polarity and absolute scaling
// RULE5: master keeps step within half span
// RULE6: limits, command, offset are signed 32-bit
// RULE7: command acts only in positioning mode
// RULE8: toggle adds or copies command to target
// RULE9: coordinate shift accumulates offset to reference
// RULE10: listed parameters locked unless password matches
// RULE11: secondary operation modes four to seven
// RULE12: mode select bits 11,9,8 shown 10,9,8
// RULE13: control bit 11 and status bit 10
// RULE14: toggle found by comparing stored bit
`timescale 1ns/1ps
module dpr_core (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    output dpr_pkg::dpr_pos_t        active_target,
    output logic      [2:0]          active_mode,
    output logic                     target_update
);

    logic [31:0]           ctrl;
    dpr_pkg::dpr_pos_t     pos_cmd;
    dpr_pkg::dpr_pos_t     pos_act;
    dpr_pkg::dpr_limits_t  lim;
    dpr_pkg::dpr_pos_t     modulo;
    logic [31:0]           polarity;
    logic [31:0]           scaling;
    dpr_pkg::dpr_pos_t     pcmd;
    logic [31:0]           pcw;
    dpr_pkg::dpr_pos_t     coffset;
    logic [31:0]           password;
    logic [7:0]            prot [dpr_pkg::PROT_N];
    logic [15:0]           mode_def [dpr_pkg::MODE_N];
    dpr_pkg::dpr_state_t   state;
    dpr_pkg::dpr_pos_t     latched_cmd;
    logic                  latched_abs;
    logic                  toggle_prev;

    logic [31:0]           next_ctrl;
    dpr_pkg::dpr_pos_t     next_pos_cmd;
    dpr_pkg::dpr_pos_t     next_pos_act;
    dpr_pkg::dpr_limits_t  next_lim;
    dpr_pkg::dpr_pos_t     next_modulo;
    logic [31:0]           next_polarity;
    logic [31:0]           next_scaling;
    dpr_pkg::dpr_pos_t     next_pcmd;
    logic [31:0]           next_pcw;
    dpr_pkg::dpr_pos_t     next_coffset;
    logic [31:0]           next_password;
    logic [7:0]            next_prot [dpr_pkg::PROT_N];
    logic [15:0]           next_mode_def [dpr_pkg::MODE_N];
    dpr_pkg::dpr_state_t   next_state;
    dpr_pkg::dpr_pos_t     next_latched_cmd;
    logic                  next_latched_abs;
    logic                  next_toggle_prev;
    dpr_pkg::dpr_pos_t     next_target;
    logic [31:0]           next_prdata;
    logic                  access;
    logic                  mapped;
    logic                  unlocked;
    logic                  blocked;
    logic                  wr;
    logic                  lim_en;
    logic                  modulo_set;
    logic                  pos_mode;
    logic                  tgl;
    logic                  wrap_over;
    logic                  wrap_under;
    dpr_pkg::dpr_pos_t     span;
    logic [31:0]           status;

    // offset inside the protection list
    function automatic logic prot_hit(input logic [7:0] a,
                                      input logic [7:0] l0, l1, l2, l3);
        prot_hit = (a == l0) || (a == l1) || (a == l2) || (a == l3);
    endfunction

    // offset decode for the address map
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a[1:0] == 2'b00) &&
                    ((a <= dpr_pkg::OFF_PASSWORD) ||
                     (a >= dpr_pkg::OFF_PROT0 &&
                      a < dpr_pkg::OFF_PROT0 + 8'h10) ||
                     (a >= dpr_pkg::OFF_MODE0 &&
                      a < dpr_pkg::OFF_MODE0 + 8'h20));
    endfunction

    assign access   = psel && penable;
    assign mapped   = is_mapped(paddr);
    assign unlocked = (password == dpr_pkg::PASSWORD_KEY);
    assign blocked  = pwrite && !unlocked && //RULE10
                      prot_hit(paddr, prot[0], prot[1], prot[2], prot[3]);
    assign pready   = 1'b1;
    assign pslverr  = access && (!mapped || blocked);
    assign wr       = access && pwrite && mapped && !blocked;
    assign modulo_set = (modulo != dpr_pkg::RST_ZERO); //RULE1
    assign lim_en = polarity[dpr_pkg::POL_LIM_EN] &&
                    scaling[dpr_pkg::SCL_ABS] && modulo_set; //RULE4 RULE2
    assign span   = lim.overflow - lim.underflow; //RULE6
    assign wrap_over  = lim_en && (pos_act >= lim.overflow); //RULE3
    assign wrap_under = lim_en && (pos_act < lim.underflow); //RULE3
    assign active_mode = {ctrl[dpr_pkg::CW_SEL_HI], ctrl[dpr_pkg::CW_SEL_MID],
                          ctrl[dpr_pkg::CW_SEL_LO]}; //RULE12 RULE13
    assign pos_mode = (mode_def[active_mode] ==
                       dpr_pkg::MODE_POSITIONING); //RULE11
    assign tgl = wr && (paddr == dpr_pkg::OFF_PCW) && pos_mode && //RULE7
                 (pwdata[dpr_pkg::PCW_TOGGLE] != toggle_prev); //RULE14
    always_comb begin
        status = dpr_pkg::RST_ZERO;
        status[dpr_pkg::SW_ACT_HI]  = active_mode[2]; //RULE13
        status[dpr_pkg::SW_ACT_MID] = active_mode[1];
        status[dpr_pkg::SW_ACT_LO]  = active_mode[0];
        status[dpr_pkg::SW_LIM_EN]  = lim_en;
    end

    // register writes and wrap correction
    always_comb begin
        next_ctrl     = ctrl;
        next_pos_cmd  = pos_cmd;
        next_pos_act  = pos_act;
        next_lim      = lim;
        next_modulo   = modulo;
        next_polarity = polarity;
        next_scaling  = scaling;
        next_pcmd     = pcmd;
        next_pcw      = pcw;
        next_coffset  = coffset;
        next_password = password;
        next_prot     = prot;
        next_mode_def = mode_def;
        next_toggle_prev = toggle_prev;
        // wrap by one span; step bounded by master to half span
        if (wrap_over) begin
            next_pos_act = pos_act - span; //RULE3 RULE5
            next_pos_cmd = pos_cmd - span; //RULE3
        end else if (wrap_under) begin
            next_pos_act = pos_act + span; //RULE3
            next_pos_cmd = pos_cmd + span; //RULE3
        end
        if (wr) begin
            case (paddr)
                dpr_pkg::OFF_CTRL:     next_ctrl     = pwdata;
                dpr_pkg::OFF_POS_CMD:  next_pos_cmd  = pwdata;
                dpr_pkg::OFF_POS_ACT:  next_pos_act  = pwdata;
                dpr_pkg::OFF_UNDER:    next_lim.underflow = pwdata;
                dpr_pkg::OFF_OVER:     next_lim.overflow  = pwdata;
                dpr_pkg::OFF_MODULO:   next_modulo   = pwdata;
                dpr_pkg::OFF_POLARITY: next_polarity = pwdata;
                dpr_pkg::OFF_SCALING:  next_scaling  = pwdata;
                dpr_pkg::OFF_PCMD:     next_pcmd     = pwdata;
                dpr_pkg::OFF_PCW: begin
                    next_pcw = pwdata;
                    next_toggle_prev = pwdata[dpr_pkg::PCW_TOGGLE]; //RULE14
                end
                dpr_pkg::OFF_COORD:
                    next_coffset = coffset + (pwdata - pos_act); //RULE9
                dpr_pkg::OFF_PASSWORD: next_password = pwdata;
                default: begin
                    for (int i = 0; i < dpr_pkg::PROT_N; i++) begin
                        if (paddr == dpr_pkg::OFF_PROT0 + 8'(4 * i)) begin
                            next_prot[i] = pwdata[7:0];
                        end
                    end
                    for (int i = 0; i < dpr_pkg::MODE_N; i++) begin
                        if (paddr == dpr_pkg::OFF_MODE0 + 8'(4 * i)) begin
                            next_mode_def[i] = pwdata[15:0]; //RULE11
                        end
                    end
                end
            endcase
        end
    end

    // positioning target update
    always_comb begin
        next_state       = state;
        next_target      = active_target;
        next_latched_cmd = latched_cmd;
        next_latched_abs = latched_abs;
        case (state)
            dpr_pkg::DPR_ST_IDLE: begin
                if (tgl) begin
                    next_latched_cmd = pcmd;
                    next_latched_abs = pcw[dpr_pkg::PCW_ABS];
                    next_state = dpr_pkg::DPR_ST_APPLY;
                end
            end
            dpr_pkg::DPR_ST_APPLY: begin
                next_target = latched_abs ? latched_cmd :
                              active_target + latched_cmd; //RULE8
                next_state = dpr_pkg::DPR_ST_IDLE;
            end
            default: next_state = dpr_pkg::DPR_ST_IDLE;
        endcase
    end

    // read data sampled in the setup phase
    always_comb begin
        next_prdata = prdata;
        if (psel && !penable) begin
            case (paddr)
                dpr_pkg::OFF_CTRL:     next_prdata = ctrl;
                dpr_pkg::OFF_STATUS:   next_prdata = status;
                dpr_pkg::OFF_POS_CMD:  next_prdata = pos_cmd;
                dpr_pkg::OFF_POS_ACT:  next_prdata = pos_act;
                dpr_pkg::OFF_UNDER:    next_prdata = lim.underflow;
                dpr_pkg::OFF_OVER:     next_prdata = lim.overflow;
                dpr_pkg::OFF_MODULO:   next_prdata = modulo;
                dpr_pkg::OFF_POLARITY: next_prdata = polarity;
                dpr_pkg::OFF_SCALING:  next_prdata = scaling;
                dpr_pkg::OFF_PCMD:     next_prdata = pcmd;
                dpr_pkg::OFF_PCW:      next_prdata = pcw;
                dpr_pkg::OFF_TARGET:   next_prdata = active_target;
                dpr_pkg::OFF_COFFSET:  next_prdata = coffset;
                dpr_pkg::OFF_PASSWORD: next_prdata = {31'h0000_0000, unlocked};
                default: begin
                    next_prdata = dpr_pkg::RST_ZERO;
                    for (int i = 0; i < dpr_pkg::PROT_N; i++) begin
                        if (paddr == dpr_pkg::OFF_PROT0 + 8'(4 * i)) begin
                            next_prdata = {24'h00_0000, prot[i]};
                        end
                    end
                    for (int i = 0; i < dpr_pkg::MODE_N; i++) begin
                        if (paddr == dpr_pkg::OFF_MODE0 + 8'(4 * i)) begin
                            next_prdata = {16'h0000, mode_def[i]};
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl          <= dpr_pkg::RST_ZERO;
            pos_cmd       <= dpr_pkg::RST_ZERO;
            pos_act       <= dpr_pkg::RST_ZERO;
            lim           <= {dpr_pkg::RST_ZERO, dpr_pkg::RST_ZERO};
            modulo        <= dpr_pkg::RST_ZERO;
            polarity      <= dpr_pkg::RST_ZERO;
            scaling       <= dpr_pkg::RST_ZERO;
            pcmd          <= dpr_pkg::RST_ZERO;
            pcw           <= dpr_pkg::RST_ZERO;
            coffset       <= dpr_pkg::RST_ZERO;
            password      <= dpr_pkg::RST_ZERO;
            prot          <= '{default: dpr_pkg::RST_PROT};
            mode_def      <= '{default: dpr_pkg::RST_MODE};
            toggle_prev   <= 1'b0;
            state         <= dpr_pkg::DPR_ST_IDLE;
            active_target <= dpr_pkg::RST_ZERO;
            latched_cmd   <= dpr_pkg::RST_ZERO;
            latched_abs   <= 1'b0;
            prdata        <= dpr_pkg::RST_ZERO;
            target_update <= 1'b0;
        end else begin
            ctrl          <= next_ctrl;
            pos_cmd       <= next_pos_cmd;
            pos_act       <= next_pos_act;
            lim           <= next_lim;
            modulo        <= next_modulo;
            polarity      <= next_polarity;
            scaling       <= next_scaling;
            pcmd          <= next_pcmd;
            pcw           <= next_pcw;
            coffset       <= next_coffset;
            password      <= next_password;
            prot          <= next_prot;
            mode_def      <= next_mode_def;
            toggle_prev   <= next_toggle_prev;
            state         <= next_state;
            active_target <= next_target;
            latched_cmd   <= next_latched_cmd;
            latched_abs   <= next_latched_abs;
            prdata        <= next_prdata;
            target_update <= (state == dpr_pkg::DPR_ST_APPLY);
        end
    end

    default clocking dpr_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence seq_toggle_rel;
        tgl && !pcw[dpr_pkg::PCW_ABS];
    endsequence
    sequence seq_apply;
        state == dpr_pkg::DPR_ST_APPLY;
    endsequence
    chk_wrap_act: assert property (wrap_over && !wr |=> //RULE3
        pos_act == $past(pos_act) - $past(span))
        else $error("actual position not wrapped at overflow");
    chk_wrap_cmd: assert property (wrap_under && !wr |=> //RULE3
        pos_cmd == $past(pos_cmd) + $past(span))
        else $error("commanded position not wrapped at underflow");
    chk_limit_gate: assert property (!lim_en && !wr |=> //RULE4
        $stable(pos_act) && $stable(pos_cmd))
        else $error("position changed with limits disabled");
    chk_toggle_rel: assert property (seq_toggle_rel ##1 seq_apply |=> //RULE8
        active_target == $past(active_target) + $past(latched_cmd)
        && target_update)
        else $error("relative target not added");
    chk_toggle_once: assert property (tgl |=> //RULE14
        seq_apply ##1 state == dpr_pkg::DPR_ST_IDLE)
        else $error("toggle did not start one update");
    chk_mode_gate: assert property ( //RULE7
        state == dpr_pkg::DPR_ST_IDLE && !tgl |=> $stable(active_target)[*2])
        else $error("target moved without toggle");
    chk_mode_block: assert property ( //RULE7
        wr && paddr == dpr_pkg::OFF_PCW && !pos_mode |=> $stable(state))
        else $error("toggle acted outside positioning mode");
    chk_status_mode: assert property ( //RULE12
        status[10:8] == {ctrl[11], ctrl[9], ctrl[8]})
        else $error("status mode bits differ from control");
    chk_protect_wr: assert property (access && blocked |-> pslverr ##1 //RULE10
        $stable(pcmd) && $stable(ctrl) && $stable(password))
        else $error("protected write not refused");
    chk_offset_acc: assert property ( //RULE9
        wr && paddr == dpr_pkg::OFF_COORD |=>
            coffset == $past(coffset) + $past(pwdata) - $past(pos_act))
        else $error("coordinate offset not accumulated");

endmodule

// >>> bench/dpr_ctrl_model.sv
/*
 * dpr_ctrl_model: motion controller side of the block, an APB master
 * that issues cyclic command writes and parameter reads.
 * Assumes an APB slave on pclk that may add wait states.
 */
`timescale 1ns/1ps
module dpr_ctrl_model (
    input  wire logic        pclk,
    input  wire logic        pready,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end

    // request held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        // released bus shows no stale request
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask
endmodule

// >>> bench/tb.sv
/*
 * tb: self-checking bench for dpr_core; expected results are queued by
 * the driver and compared by monitors. Assumes dpr_ctrl_model as master.
 */
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic        rd;
        logic        err;
        logic [31:0] d;
    } dpr_exp_t;
    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [7:0]        paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    dpr_pkg::dpr_pos_t active_target;
    logic [2:0]        active_mode;
    logic              target_update;
    dpr_exp_t          q[$];
    dpr_exp_t          x;
    logic [31:0]       tq[$];
    int                n_mismatch;
    int                checked;
    integer            seed;
    dpr_pkg::dpr_pos_t p1;
    dpr_pkg::dpr_pos_t p2;
    logic [15:0]       r;

    dpr_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .active_target(active_target),
        .active_mode(active_mode), .target_update(target_update));

    dpr_ctrl_model mdl (.pclk(pclk), .pready(pready), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic note(input string nm, input logic [31:0] e,
                        input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // write data, or expected read data for a read
    task automatic op(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic e);
        q.push_back('{rd: !w, err: e, d: d});
        mdl.xfer(w, a, d);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge pclk) begin
        if (psel && penable) note("pready", 32'h1, {31'h0, pready});
        if (psel && penable && pready) begin
            if (q.size() == 0) begin
                note("transfer", 32'h0, 32'h1);
            end else begin
                x = q.pop_front();
                note("pslverr", {31'h0, x.err}, {31'h0, pslverr});
                if (x.rd) note("prdata", x.d, prdata);
            end
        end
        if (target_update === 1'b1) begin
            if (tq.size() == 0) note("target pulse", 32'h0, 32'h1);
            else note("active_target", tq.pop_front(), active_target);
        end
    end

    initial begin
        #200000;
        $display("unexpected timeout");
        n_mismatch++;
        test_done;
    end

    initial begin
        presetn    = 1'b0;
        seed       = 32'hEDD78436;
        n_mismatch = 0;
        checked    = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        op(0, dpr_pkg::OFF_STATUS, 32'h0, 0);
        op(0, dpr_pkg::OFF_TARGET, 32'h0, 0);
        op(0, dpr_pkg::OFF_COFFSET, 32'h0, 0);
        op(0, dpr_pkg::OFF_PASSWORD, 32'h0, 0);
        op(0, dpr_pkg::OFF_PROT0, {24'h0, dpr_pkg::RST_PROT}, 0);
        op(0, 8'h3C, 32'h0, 1);
        op(1, 8'hF0, 32'h1, 1);
        op(0, 8'h02, 32'h0, 1);
        for (int m = 0; m < 8; m++) begin
            op(1, dpr_pkg::OFF_CTRL, {20'h0, m[2], m[0], m[1], m[0], 8'hA5}, 0);
            #1;
            note("active_mode", 32'(m[2:0]), 32'(active_mode));
            op(0, dpr_pkg::OFF_STATUS, {21'h0, m[2:0], 8'h00}, 0);
            r = 16'($random(seed));
            op(1, dpr_pkg::OFF_MODE0 + 8'(4 * m), {16'h0, r}, 0);
            op(0, dpr_pkg::OFF_MODE0 + 8'(4 * m), {16'h0, r}, 0);
        end
        op(1, dpr_pkg::OFF_MODE0 + 8'h0C, 32'(dpr_pkg::MODE_POSITIONING), 0);
        op(1, dpr_pkg::OFF_MODE0 + 8'h08, 32'h1, 0);
        op(1, dpr_pkg::OFF_CTRL, 32'h300, 0);
        p1 = $random(seed) % 500;
        p2 = $random(seed) % 500;
        op(1, dpr_pkg::OFF_PCMD, p1, 0);
        op(1, dpr_pkg::OFF_PCW, 32'h2, 0);
        tq.push_back(p1);
        op(1, dpr_pkg::OFF_PCW, 32'h3, 0);
        op(1, dpr_pkg::OFF_PCMD, p2, 0);
        op(1, dpr_pkg::OFF_PCW, 32'h1, 0);
        tq.push_back(p1 + p2);
        op(1, dpr_pkg::OFF_PCW, 32'h0, 0);
        tq.push_back(p1 + 2 * p2);
        op(1, dpr_pkg::OFF_PCW, 32'h1, 0);
        op(1, dpr_pkg::OFF_CTRL, 32'h200, 0);
        op(1, dpr_pkg::OFF_PCW, 32'h0, 0);
        op(0, dpr_pkg::OFF_TARGET, p1 + 2 * p2, 0);
        op(1, dpr_pkg::OFF_CTRL, 32'h300, 0);
        op(1, dpr_pkg::OFF_PCW, 32'h0, 0);
        tq.push_back(p1 + 3 * p2);
        op(1, dpr_pkg::OFF_PCW, 32'h1, 0);
        op(1, dpr_pkg::OFF_PROT0, {24'h0, dpr_pkg::OFF_PCMD}, 0);
        op(1, dpr_pkg::OFF_PCMD, 32'h5, 1);
        op(0, dpr_pkg::OFF_PCMD, p2, 0);
        op(1, dpr_pkg::OFF_PASSWORD, dpr_pkg::PASSWORD_KEY, 0);
        op(0, dpr_pkg::OFF_PASSWORD, 32'h1, 0);
        op(1, dpr_pkg::OFF_PCMD, 32'h5, 0);
        op(0, dpr_pkg::OFF_PCMD, 32'h5, 0);
        op(1, dpr_pkg::OFF_UNDER, -1000, 0);
        op(1, dpr_pkg::OFF_OVER, 1000, 0);
        op(1, dpr_pkg::OFF_POLARITY, 32'h80, 0);
        op(1, dpr_pkg::OFF_SCALING, 32'h40, 0);
        op(1, dpr_pkg::OFF_POS_CMD, 1200, 0);
        op(1, dpr_pkg::OFF_POS_ACT, 1500, 0);
        op(0, dpr_pkg::OFF_STATUS, 32'h300, 0);
        op(0, dpr_pkg::OFF_POS_ACT, 1500, 0);
        op(1, dpr_pkg::OFF_MODULO, 2000, 0);
        op(0, dpr_pkg::OFF_STATUS, 32'h301, 0);
        op(0, dpr_pkg::OFF_POS_ACT, -500, 0);
        op(0, dpr_pkg::OFF_POS_CMD, -800, 0);
        op(1, dpr_pkg::OFF_POS_ACT, -1001, 0);
        op(0, dpr_pkg::OFF_POS_ACT, 999, 0);
        op(0, dpr_pkg::OFF_POS_CMD, 1200, 0);
        op(1, dpr_pkg::OFF_POS_ACT, 1000, 0);
        op(0, dpr_pkg::OFF_POS_ACT, -1000, 0);
        op(0, dpr_pkg::OFF_POS_CMD, -800, 0);
        op(1, dpr_pkg::OFF_POLARITY, 32'h0, 0);
        op(0, dpr_pkg::OFF_STATUS, 32'h300, 0);
        op(1, dpr_pkg::OFF_COORD, 5000, 0);
        op(0, dpr_pkg::OFF_COFFSET, 6000, 0);
        op(1, dpr_pkg::OFF_COORD, -300, 0);
        op(0, dpr_pkg::OFF_COFFSET, 6700, 0);
        op(0, dpr_pkg::OFF_COORD, 32'h0, 0);
        repeat (4) @(posedge pclk);
        note("pending", 32'h0, q.size() + tq.size());
        test_done;
    end
endmodule
